// >>> rtl/pfc_cache_ctrl.sv
/*
 * Control and tag logic of a small prefetch cache: configuration, tags,
 * hits, wait-stated flash reads, lock-aware fill, next-line prefetch and
 * program invalidation. Assumes flash data valid once the wait states
 * have passed, fetch pulses only while fetch_busy_out is low.
 */
`include "pfc_cfg.svh"
`default_nettype none
module pfc_cache_ctrl
	import pfc_pkg::*;
#(
	parameter int LINES = 16,
	parameter int DATA_MAX = 4
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic fetch_req_in,
	input wire logic [31:0] fetch_addr_in,
	input wire logic fetch_instr_in,
	input wire logic fetch_cacheable_in,
	output logic fetch_busy_out,
	output logic fetch_ack_out,
	output logic fetch_hit_out,
	output logic [31:0] fetch_data_out,
	output logic flash_rd_out,
	output logic [31:0] flash_addr_out,
	input wire logic [31:0] flash_rdata_in,
	input wire logic flash_program_in
);
	localparam int IW = $clog2(LINES);
	// ****************************************************************
	// configuration registers
	// ****************************************************************
	logic coherency_invalidate_all_r;
	logic [1:0] data_line_count_r, predictive_prefetch_select_r;
	logic [2:0] flash_wait_states_r;
	logic [IW-1:0] line_select_r;

	// line storage
	logic tag_boot_region_r [LINES], line_valid_flag_r [LINES];
	logic line_lock_flag_r [LINES], line_content_kind_r [LINES];
	logic [19:0] line_tag_address_r [LINES];
	logic [1:0] line_word_r [LINES];
	logic [31:0] line_data_r [LINES];
	pfc_state_t state_r;
	logic [2:0] wait_cnt_r;
	logic [31:0] miss_addr_r;
	logic miss_instr_r, miss_cacheable_r, is_prefetch_r;
	logic [IW-1:0] repl_ptr_r;
	logic wr_ctrl, wr_tag, dlc_change, hit, fill_ok, fill_now;
	logic fetch_take, pref_want;
	logic [2:0] data_lines;
	logic [IW-1:0] hit_idx, victim;

	assign wr_ctrl = clk_en_in && reg_wr_in &&
		reg_addr_in == `PFC_OFS_CACHE_CONTROL;
	assign wr_tag = clk_en_in && reg_wr_in &&
		reg_addr_in == `PFC_OFS_CACHE_LINE_TAG;
	assign dlc_change = wr_ctrl &&
		reg_wdata_in[`PFC_CC_DLC_LO +: 2] != data_line_count_r;

	// data line budget from the two-bit count
	always_comb begin
		unique case (data_line_count_r)
			2'h3: data_lines = 3'h4;
			2'h2: data_lines = 3'h2;
			2'h1: data_lines = 3'h1;
			2'h0: data_lines = 3'h0;
		endcase
	end

	// ****************************************************************
	// register writes
	// ****************************************************************
	// only the documented fields are stored, the rest is dropped
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			coherency_invalidate_all_r <= 1'b0;
			data_line_count_r <= `PFC_CC_RESET_DLC;
			predictive_prefetch_select_r <= `PFC_CC_RESET_PREF;
			flash_wait_states_r <= `PFC_CC_RESET_WS;
		end else if (wr_ctrl) begin
			coherency_invalidate_all_r <=
				reg_wdata_in[`PFC_CC_COHERENCY_BIT];
			data_line_count_r <= reg_wdata_in[`PFC_CC_DLC_LO +: 2];
			predictive_prefetch_select_r <=
				reg_wdata_in[`PFC_CC_PREF_LO +: 2];
			flash_wait_states_r <= reg_wdata_in[`PFC_CC_WS_LO +: 3];
		end
	end

	// line index that the tag register views
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			line_select_r <= '0;
		end else if (clk_en_in && reg_wr_in &&
				reg_addr_in == `PFC_OFS_LINE_SELECT) begin
			line_select_r <= reg_wdata_in[IW-1:0];
		end
	end

	// read data stand for exactly one cycle after the strobe
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			reg_rdata_out <= 32'h0000_0000;
		end else if (clk_en_in) begin
			reg_rdata_out <= 32'h0000_0000;
			if (reg_rd_in) begin
				unique case (reg_addr_in)
					`PFC_OFS_CACHE_CONTROL: begin
						reg_rdata_out[`PFC_CC_COHERENCY_BIT] <=
							coherency_invalidate_all_r;
						reg_rdata_out[`PFC_CC_DLC_LO +: 2] <= data_line_count_r;
						reg_rdata_out[`PFC_CC_PREF_LO +: 2] <=
							predictive_prefetch_select_r;
						reg_rdata_out[`PFC_CC_WS_LO +: 3] <= flash_wait_states_r;
					end
					`PFC_OFS_CACHE_LINE_TAG: begin
						reg_rdata_out[`PFC_TAG_BOOT_BIT] <=
							tag_boot_region_r[line_select_r];
						reg_rdata_out[`PFC_TAG_ADDR_LO +: 20] <=
							line_tag_address_r[line_select_r];
						reg_rdata_out[`PFC_TAG_VALID_BIT] <=
							line_valid_flag_r[line_select_r];
						reg_rdata_out[`PFC_TAG_LOCK_BIT] <=
							line_lock_flag_r[line_select_r];
						reg_rdata_out[`PFC_TAG_KIND_BIT] <=
							line_content_kind_r[line_select_r];
					end
					`PFC_OFS_LINE_SELECT: reg_rdata_out[IW-1:0] <= line_select_r;
					`PFC_OFS_STATUS: reg_rdata_out[1:0] <= {is_prefetch_r, fetch_busy_out};
					default: reg_rdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************************************
	// hit detection and victim choice
	// ****************************************************************
	// the boot bit stands for the area byte of the physical address
	function automatic logic area_ok(input logic boot, input logic [7:0] a);
		area_ok = boot ? (a == `PFC_AREA_BOOT_ONE) :
			(a == `PFC_AREA_BOOT_ZERO);
	endfunction : area_ok
	// first valid line of matching tag, word, area and kind wins
	always_comb begin
		hit = 1'b0;
		hit_idx = '0;
		for (int i = 0; i < LINES; i++) begin
			if (line_valid_flag_r[i] &&
					line_tag_address_r[i] == fetch_addr_in[23:4] &&
					line_word_r[i] == fetch_addr_in[3:2] &&
					area_ok(tag_boot_region_r[i], fetch_addr_in[31:24]) &&
					line_content_kind_r[i] == fetch_instr_in &&
					!hit) begin
				hit = 1'b1;
				hit_idx = IW'(i);
			end
		end
	end

	// data lines live below DATA_MAX, instruction lines at and above it;
	// scanning from the round-robin pointer spreads the wear
	always_comb begin
		fill_ok = 1'b0;
		victim = '0;
		for (int k = 0; k < LINES; k++) begin
			logic [IW-1:0] j;
			j = IW'((32'(repl_ptr_r) + k) % LINES);
			if (!fill_ok && !line_lock_flag_r[j] &&
					(miss_instr_r ? (32'(j) >= DATA_MAX) :
					(32'(j) < 32'(data_lines)))) begin
				fill_ok = 1'b1;
				victim = j;
			end
		end
	end

	// a region gets prefetch only where the select allows it
	assign pref_want = !is_prefetch_r &&
		(miss_cacheable_r ? predictive_prefetch_select_r[0] :
		predictive_prefetch_select_r[1]);
	assign fill_now = clk_en_in && state_r == PFC_WAIT &&
		wait_cnt_r == 3'h0 && fill_ok &&
		(miss_cacheable_r || is_prefetch_r);
	assign fetch_take = clk_en_in && fetch_req_in && state_r == PFC_IDLE;

	// ****************************************************************
	// line tag array
	// ****************************************************************
	// invalidation beats a fill in the same cycle, otherwise stale flash
	// contents could survive a program cycle
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			for (int i = 0; i < LINES; i++) begin
				tag_boot_region_r[i] <= 1'b0;
				line_tag_address_r[i] <= 20'h0_0000;
				line_valid_flag_r[i] <= 1'b0;
				line_lock_flag_r[i] <= 1'b0;
				line_content_kind_r[i] <= `PFC_TAG_RESET_KIND;
				line_word_r[i] <= 2'h0;
				line_data_r[i] <= 32'h0000_0000;
			end
		end else if (clk_en_in) begin
			if (fill_now) begin
				tag_boot_region_r[victim] <=
					miss_addr_r[31:24] == `PFC_AREA_BOOT_ONE;
				line_tag_address_r[victim] <= miss_addr_r[23:4];
				line_word_r[victim] <= miss_addr_r[3:2];
				line_data_r[victim] <= flash_rdata_in;
				line_valid_flag_r[victim] <= 1'b1;
				line_content_kind_r[victim] <= miss_instr_r;
			end
			if (wr_tag) begin
				tag_boot_region_r[line_select_r] <=
					reg_wdata_in[`PFC_TAG_BOOT_BIT];
				line_tag_address_r[line_select_r] <=
					reg_wdata_in[`PFC_TAG_ADDR_LO +: 20];
				line_valid_flag_r[line_select_r] <=
					reg_wdata_in[`PFC_TAG_VALID_BIT];
				line_lock_flag_r[line_select_r] <=
					reg_wdata_in[`PFC_TAG_LOCK_BIT];
				line_content_kind_r[line_select_r] <=
					reg_wdata_in[`PFC_TAG_KIND_BIT];
			end
			for (int i = 0; i < LINES; i++) begin
				if (dlc_change) begin
					line_valid_flag_r[i] <= 1'b0;
				end else if (flash_program_in &&
						(coherency_invalidate_all_r ||
						!line_content_kind_r[i] ||
						!line_lock_flag_r[i])) begin
					line_valid_flag_r[i] <= 1'b0;
				end
			end
		end
	end

	// replacement pointer moves past each filled line
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			repl_ptr_r <= '0;
		end else if (fill_now) begin
			repl_ptr_r <= IW'((32'(victim) + 1) % LINES);
		end
	end

	// ****************************************************************
	// fetch and flash sequencing
	// ****************************************************************
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_r <= PFC_IDLE;
			wait_cnt_r <= 3'h0;
			miss_addr_r <= 32'h0000_0000;
			miss_instr_r <= 1'b0;
			miss_cacheable_r <= 1'b0;
			is_prefetch_r <= 1'b0;
			flash_rd_out <= 1'b0;
			flash_addr_out <= 32'h0000_0000;
			fetch_busy_out <= 1'b0;
			fetch_ack_out <= 1'b0;
			fetch_hit_out <= 1'b0;
			fetch_data_out <= 32'h0000_0000;
		end else if (clk_en_in) begin
			fetch_ack_out <= 1'b0;
			fetch_hit_out <= 1'b0;
			unique case (state_r)
				PFC_IDLE: begin
					if (fetch_take && hit) begin
						fetch_ack_out <= 1'b1;
						fetch_hit_out <= 1'b1;
						fetch_data_out <= line_data_r[hit_idx];
					end else if (fetch_take) begin
						state_r <= PFC_WAIT;
						wait_cnt_r <= flash_wait_states_r;
						miss_addr_r <= fetch_addr_in;
						miss_instr_r <= fetch_instr_in;
						miss_cacheable_r <= fetch_cacheable_in;
						is_prefetch_r <= 1'b0;
						flash_rd_out <= 1'b1;
						flash_addr_out <= fetch_addr_in;
						fetch_busy_out <= 1'b1;
					end
				end
				PFC_WAIT: begin
					if (wait_cnt_r != 3'h0) begin
						wait_cnt_r <= wait_cnt_r - 3'h1;
					end else begin
						flash_rd_out <= 1'b0;
						state_r <= PFC_DONE;
						if (!is_prefetch_r) begin
							fetch_ack_out <= 1'b1;
							fetch_data_out <= flash_rdata_in;
						end
					end
				end
				PFC_DONE: begin
					// the next line is fetched only after the demand word
					if (pref_want) begin
						state_r <= PFC_WAIT;
						wait_cnt_r <= flash_wait_states_r;
						is_prefetch_r <= 1'b1;
						miss_addr_r <= miss_addr_r + `PFC_LINE_BYTES;
						flash_rd_out <= 1'b1;
						flash_addr_out <= miss_addr_r + `PFC_LINE_BYTES;
					end else begin
						state_r <= PFC_IDLE;
						is_prefetch_r <= 1'b0;
						fetch_busy_out <= 1'b0;
					end
				end
			endcase
		end
	end
endmodule : pfc_cache_ctrl
`default_nettype wire

// >>> rtl/pfc_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * prefetch cache control block. Assumes a 32-bit register port with
 * byte addresses and a 200 MHz system clock.
 */
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

// register byte addresses
`define PFC_OFS_CACHE_CONTROL 8'h00
`define PFC_OFS_CACHE_LINE_TAG 8'h04
`define PFC_OFS_LINE_SELECT 8'h08
`define PFC_OFS_STATUS 8'h0c

// cache_control fields
`define PFC_CC_COHERENCY_BIT 16
`define PFC_CC_DLC_LO 8
`define PFC_CC_PREF_LO 4
`define PFC_CC_WS_LO 0
`define PFC_CC_RESET_WS 3'h7
`define PFC_CC_RESET_DLC 2'h0
`define PFC_CC_RESET_PREF 2'h0

// cache_line_tag fields
`define PFC_TAG_BOOT_BIT 31
`define PFC_TAG_ADDR_LO 4
`define PFC_TAG_VALID_BIT 3
`define PFC_TAG_LOCK_BIT 2
`define PFC_TAG_KIND_BIT 1
`define PFC_TAG_RESET_KIND 1'h1

// physical areas chosen by the boot-region bit (address bits 31:24)
`define PFC_AREA_BOOT_ONE 8'h1d
`define PFC_AREA_BOOT_ZERO 8'h1f

// line step used for the predictive prefetch
`define PFC_LINE_BYTES 32'h0000_0010

`endif

// >>> rtl/pfc_pkg.sv
/*
 * Types of the prefetch cache control block.
 * Assumes pfc_cfg.svh for all numeric constants.
 */
`default_nettype none
package pfc_pkg;
	// one-hot flash access states
	typedef enum logic [2:0] {
		PFC_IDLE = 3'b001,
		PFC_WAIT = 3'b010,
		PFC_DONE = 3'b100
	} pfc_state_t;
endpackage : pfc_pkg
`default_nettype wire

// >>> verification/pfc_cache_ctrl_asserts.sv
/* timing checks on the cache control ports.
 assumes clk_en_in stays high and the map of pfc_cfg.svh. */
`include "pfc_cfg.svh"
`default_nettype none
module pfc_cache_ctrl_asserts (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic fetch_req_in,
	input wire logic fetch_busy_out,
	input wire logic fetch_ack_out,
	input wire logic fetch_hit_out,
	input wire logic [31:0] fetch_data_out,
	input wire logic flash_rd_out,
	input wire logic [31:0] flash_addr_out,
	input wire logic [31:0] flash_rdata_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// helpers
	// ****
	logic [2:0] ws_r;
	logic [3:0] rd_cnt_r;
	// shadow of the wait states; a change mid-access is not tracked
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			ws_r <= `PFC_CC_RESET_WS;
		else if (reg_wr_in && reg_addr_in == `PFC_OFS_CACHE_CONTROL)
			ws_r <= reg_wdata_in[`PFC_CC_WS_LO +: 3];
	end
	// length of the current flash access
	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in)
			rd_cnt_r <= 4'h0;
		else
			rd_cnt_r <= flash_rd_out ? rd_cnt_r + 4'h1 : 4'h0;
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	sequence s_taken;
		fetch_req_in && !fetch_busy_out;
	endsequence
	sequence s_miss_start;
		s_taken ##1 fetch_busy_out;
	endsequence
	a_miss_starts_rd: assert property (s_miss_start |-> flash_rd_out)
		else $error("miss without flash read");
	a_wait_count: assert property ($fell(flash_rd_out) |->
		rd_cnt_r == {1'b0, ws_r} + 4'h1) else $error("wait count wrong");
	a_miss_ack_end: assert property (fetch_ack_out && !fetch_hit_out
		|-> $fell(flash_rd_out) && fetch_busy_out)
		else $error("miss ack off time");
	a_miss_word: assert property (fetch_ack_out && !fetch_hit_out
		|-> fetch_data_out == $past(flash_rdata_in))
		else $error("miss word wrong");
	a_hit_cause: assert property (fetch_hit_out |-> fetch_ack_out &&
		$past(fetch_req_in && !fetch_busy_out)) else $error("stray hit");
	a_ack_single: assert property (fetch_ack_out && !fetch_hit_out
		|=> !fetch_ack_out) else $error("ack too long");
	a_addr_hold: assert property (flash_rd_out && $past(flash_rd_out)
		|-> $stable(flash_addr_out)) else $error("flash address moved");
	a_rd_in_busy: assert property (flash_rd_out |-> fetch_busy_out)
		else $error("flash read while idle");
	a_rdata_idle: assert property (reg_rdata_out != 32'h0 |->
		$past(reg_rd_in)) else $error("read data without read");
endmodule : pfc_cache_ctrl_asserts
bind pfc_cache_ctrl pfc_cache_ctrl_asserts i_chk (
	.sys_clk_in(sys_clk_in), .reset_in(reset_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .fetch_req_in(fetch_req_in),
	.fetch_busy_out(fetch_busy_out), .fetch_ack_out(fetch_ack_out),
	.fetch_hit_out(fetch_hit_out), .fetch_data_out(fetch_data_out),
	.flash_rd_out(flash_rd_out), .flash_addr_out(flash_addr_out),
	.flash_rdata_in(flash_rdata_in));
`default_nettype wire

// >>> verification/pfc_flash_model.sv
/* flash array model for the fetch side of the cache control.
 assumes a read is held while flash_rd_in is high, 1 to 8 clocks. */
`default_nettype none
module pfc_flash_model (
	input wire logic flash_rd_in,
	input wire logic [31:0] flash_addr_in,
	output logic [31:0] flash_rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// word pattern
	// ****
	function automatic logic [31:0] word_of(input logic [31:0] a);
		return {a[15:0] ^ 16'h5a5a, a[31:16]};
	endfunction : word_of
	// an idle bus shows the inverse, so a stale sample never matches
	assign flash_rdata_out = flash_rd_in ? word_of(flash_addr_in) :
		~word_of(flash_addr_in);
endmodule : pfc_flash_model
`default_nettype wire

// >>> verification/tb_pfc_cache_ctrl.sv
/* self-checking bench of the prefetch cache control.
 assumes the flash model and the bound checker are compiled. */
`default_nettype none
module tb_pfc_cache_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// wiring
	// ****
	logic clk = 1'b0, rst = 1'b1, wr, rd, req, instr, cach, prog;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, faddr, fdout, fla, frdat;
	logic busy, ack, hit, frd;
	int n_errors = 0, tests_run = 0, cyc = 0;
	pfc_cache_ctrl i_dut (.sys_clk_in(clk), .reset_in(rst),
		.clk_en_in(1'b1), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.fetch_req_in(req), .fetch_addr_in(faddr),
		.fetch_instr_in(instr), .fetch_cacheable_in(cach),
		.fetch_busy_out(busy), .fetch_ack_out(ack), .fetch_hit_out(hit),
		.fetch_data_out(fdout), .flash_rd_out(frd), .flash_addr_out(fla),
		.flash_rdata_in(frdat), .flash_program_in(prog));
	pfc_flash_model i_flash (.flash_rd_in(frd), .flash_addr_in(fla),
		.flash_rdata_out(frdat));
	initial begin
		forever #2.5 clk = ~clk;
	end
	// cut a hang short; the full run needs far fewer cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			report_and_stop;
		end
	end
	// ****
	// tasks
	// ****
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	// one fetch; lat counts edges from request to ack
	task automatic fetch(input logic [31:0] a, input logic ins, c,
		output logic [31:0] h, lat);
		int k;
		@(posedge clk);
		req <= 1'b1;
		faddr <= a;
		instr <= ins;
		cach <= c;
		lat = 0;
		do begin
			@(posedge clk);
			req <= 1'b0;
			lat++;
			#1;
		end while (ack !== 1'b1 && lat < 40);
		chk("fetch ack", {31'h0, ack}, 32'h1);
		h = 32'(hit);
		if (hit !== 1'b1) chk("miss word", fdout, i_flash.word_of(a));
		for (k = 0; k < 40 && busy !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		chk("busy end", {31'h0, busy}, 32'h0);
	endtask : fetch
	task automatic pulse_prog;
		@(posedge clk);
		prog <= 1'b1;
		@(posedge clk);
		prog <= 1'b0;
	endtask : pulse_prog
	function automatic logic [31:0] rnd_addr(input logic boot);
		return {boot ? 8'h1d : 8'h1f, 20'($urandom()), 4'h0};
	endfunction : rnd_addr
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	// ****
	// tests
	// ****
	initial begin
		logic [31:0] d, a, x, h, lat;
		logic [31:0] q[4];
		int cap;
		{addr, wdata, wr, rd, req, faddr, instr, cach, prog} = '0;
		void'($urandom(32'h1438));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rreg(8'h00, d);
		chk("ctl reset", d, 32'h7);
		wreg(8'h00, '1);
		rreg(8'h00, d);
		chk("ctl mask", d, 32'h0001_0337);
		rreg(8'h40, d);
		chk("unmapped", d, 32'h0);
		rreg(8'h0c, d);
		chk("status idle", d, 32'h0);
		$display("test registers done");
		// every wait state, then a hit and a kind mismatch
		for (int w = 0; w < 8; w++) begin
			wreg(8'h00, 32'(w));
			a = rnd_addr(w[0]);
			fetch(a, 1'b1, 1'b1, h, lat);
			chk("miss latency", lat, 32'(w + 2));
			fetch(a, 1'b1, 1'b1, h, lat);
			chk("hit", {h[0], lat[30:0]}, 32'h8000_0001);
			chk("hit word", fdout, i_flash.word_of(a));
			fetch(a, 1'b0, 1'b1, h, lat);
			chk("kind", h, 32'h0);
		end
		$display("test wait states done");
		// each count change drops lines; then n data lines hold, four for n of 3
		for (int n = 3; n >= 0; n--) begin
			x = rnd_addr(1'b1);
			fetch(x, 1'b1, 1'b1, h, lat);
			wreg(8'h00, 32'(n) << 8);
			fetch(x, 1'b1, 1'b1, h, lat);
			chk("count flush", h, 32'h0);
			cap = (n == 3) ? 4 : n;
			for (int i = 0; i < 4; i++) q[i] = rnd_addr(1'b0);
			for (int i = 0; i < 4; i++) if (i < cap || i == 0)
				fetch(q[i], 1'b0, 1'b1, h, lat);
			for (int i = 0; i < 4; i++) if (i < cap || i == 0) begin
				fetch(q[i], 1'b0, 1'b1, h, lat);
				chk("data lines", h, 32'(cap != 0));
			end
		end
		$display("test data lines done");
		// locked tag in each area survives churn and soft flush
		for (int b = 0; b < 2; b++) begin
			a = rnd_addr(b[0]);
			wreg(8'h08, 32'h4);
			rreg(8'h08, d);
			chk("select", d, 32'h4);
			wreg(8'h04, {b[0], 7'h0, a[23:4], 4'he});
			rreg(8'h04, d);
			chk("tag", d, {b[0], 7'h0, a[23:4], 4'he});
			for (int i = 0; i < 14; i++)
				fetch(rnd_addr(b[0]), 1'b1, 1'b1, h, lat);
			fetch(a, 1'b1, 1'b1, h, lat);
			chk("locked kept", h, 32'h1);
			x = rnd_addr(b[0]);
			fetch(x, 1'b1, 1'b1, h, lat);
			wreg(8'h00, 32'h0);
			pulse_prog;
			fetch(a, 1'b1, 1'b1, h, lat);
			chk("soft keep", h, 32'h1);
			fetch(x, 1'b1, 1'b1, h, lat);
			chk("soft drop", h, 32'h0);
			wreg(8'h00, 32'h0001_0000);
			pulse_prog;
			fetch(a, 1'b1, 1'b1, h, lat);
			chk("hard drop", h, 32'h0);
		end
		$display("test lock and flush done");
		// every prefetch select against both region kinds
		for (int s = 0; s < 8; s++) begin
			wreg(8'h00, 32'(s[1:0]) << 4);
			a = rnd_addr(s[0]);
			fetch(a, 1'b1, s[2], h, lat);
			fetch(a + 32'h10, 1'b1, 1'b1, h, lat);
			chk("prefetch", h, 32'(s[2] ? s[0] : s[1]));
			if (h[0])
				chk("pf word", fdout, i_flash.word_of(a + 32'h10));
		end
		$display("test prefetch done");
		report_and_stop;
	end
endmodule : tb_pfc_cache_ctrl
`default_nettype wire
